// File: pkg/mcrf_pkg.sv
// Shared constants, opcodes and helpers for the core register set.
// Assumes one core clock and a synchronous active-high core reset.
package mcrf_pkg;

  // Direct addresses on the special register port
  localparam logic [7:0] ADDR_WREG_TOP = 8'h1f;
  localparam logic [7:0] ADDR_SP       = 8'h81;
  localparam logic [7:0] ADDR_DPL      = 8'h82;
  localparam logic [7:0] ADDR_DPH      = 8'h83;
  localparam logic [7:0] ADDR_BUSTIM   = 8'h9d;
  localparam logic [7:0] ADDR_PSW      = 8'hd0;
  localparam logic [7:0] ADDR_ACC      = 8'he0;
  localparam logic [7:0] ADDR_B        = 8'hf0;

  // Values after reset
  localparam logic [7:0]  SP_RST     = 8'h07;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [1:0]  BANK_RST   = 2'h0;
  localparam logic [7:0]  BUSTIM_RST = 8'h00;

  // Flags word bit positions
  localparam int unsigned BIT_CY  = 7;
  localparam int unsigned BIT_AC  = 6;
  localparam int unsigned BIT_F0  = 5;
  localparam int unsigned BIT_RS1 = 4;
  localparam int unsigned BIT_RS0 = 3;
  localparam int unsigned BIT_OV  = 2;
  localparam int unsigned BIT_PAR = 0;

  // Wait states per memory access and bus timing fields
  localparam logic [2:0]  WAIT_HIV     = 3'h4;
  localparam logic [2:0]  WAIT_LOV     = 3'h5;
  localparam int unsigned BT_OVR       = 7;
  localparam int unsigned BT_FETCH_LSB = 4;
  localparam int unsigned BT_DATA_LSB  = 0;
  localparam int unsigned BT_W         = 3;

  // Operations that touch the accumulator and flags
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SUM  = 4'h1,
    OP_SUMC = 4'h2,
    OP_DIFB = 4'h3,
    OP_PROD = 4'h4,
    OP_QUOT = 4'h5,
    OP_RLC  = 4'h6,
    OP_RRC  = 4'h7,
    OP_CLEAR_SIGNED_OVERRUN = 4'h8,
    OP_LOAD = 4'h9
  } mcrf_op_type;

  // Slot of a working register in the 32-entry bank area
  function automatic logic [4:0] bank_slot(input logic [1:0] rs,
                                           input logic [2:0] idx);
    bank_slot = {rs, idx};
  endfunction

endpackage

// File: logic/mcrf_arith_unit.sv
// Combinational arithmetic and flag results for one operation.
// Assumes the caller registers every result it takes.
`timescale 1ns/100ps
module mcrf_arith_unit
  import mcrf_pkg::*;
(
  input  wire logic [3:0] i_op,      // Operation code
  input  wire logic [7:0] i_acc,     // Accumulator now
  input  wire logic [7:0] i_b,       // Second operand register now
  input  wire logic [7:0] i_opnd,    // Source operand
  input  wire logic       i_cy,      // Carry now
  output logic      [7:0] o_a,       // New accumulator
  output logic      [7:0] o_b,       // New second operand
  output logic            o_cy,      // New carry
  output logic            o_ac,      // New half carry
  output logic            o_ov,      // New signed overrun
  output logic            o_wr_a,    // Accumulator takes o_a
  output logic            o_wr_b,    // Second operand takes o_b
  output logic            o_upd_cy,  // Carry takes o_cy
  output logic            o_upd_ac,  // Half carry takes o_ac
  output logic            o_upd_ov   // Overrun takes o_ov
);
  logic [8:0]  wide;
  logic [4:0]  nib;
  logic [15:0] prod;
  logic        cin;

  // Result and flag selection per operation
  always_comb begin
    cin = (i_op == OP_SUMC || i_op == OP_DIFB) ? i_cy : 1'b0;
    wide = 9'h000;
    nib = 5'h00;
    prod = i_acc * i_b;
    {o_a, o_b, o_cy, o_ac, o_ov} = {i_acc, i_b, i_cy, 1'b0, 1'b0};
    {o_wr_a, o_wr_b, o_upd_cy, o_upd_ac, o_upd_ov} = 5'h00;
    case (i_op)
      OP_SUM, OP_SUMC: begin
        wide = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, cin};
        nib = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]} + {4'h0, cin};
        o_a = wide[7:0];
        o_cy = wide[8];
        o_ac = nib[4];
        o_ov = (i_acc[7] == i_opnd[7]) && (wide[7] != i_acc[7]);
        {o_wr_a, o_upd_cy, o_upd_ac, o_upd_ov} = 4'hf;
      end
      OP_DIFB: begin
        wide = {1'b0, i_acc} - {1'b0, i_opnd} - {8'h00, cin};
        nib = {1'b0, i_acc[3:0]} - {1'b0, i_opnd[3:0]} - {4'h0, cin};
        o_a = wide[7:0];
        o_cy = wide[8];
        o_ac = nib[4];
        o_ov = (i_acc[7] != i_opnd[7]) && (wide[7] != i_acc[7]);
        {o_wr_a, o_upd_cy, o_upd_ac, o_upd_ov} = 4'hf;
      end
      OP_PROD: begin
        {o_b, o_a} = prod;
        o_cy = 1'b0;
        o_ov = (prod[15:8] != 8'h00);
        {o_wr_a, o_wr_b, o_upd_cy, o_upd_ov} = 4'hf;
      end
      OP_QUOT: begin
        o_cy = 1'b0;
        o_ov = (i_b == 8'h00);
        if (i_b != 8'h00) begin
          o_a = i_acc / i_b;
          o_b = i_acc % i_b;
          {o_wr_a, o_wr_b} = 2'h3;
        end
        {o_upd_cy, o_upd_ov} = 2'h3;
      end
      OP_RLC: begin
        {o_cy, o_a} = {i_acc, i_cy};
        {o_wr_a, o_upd_cy} = 2'h3;
      end
      OP_RRC: begin
        {o_a, o_cy} = {i_cy, i_acc};
        {o_wr_a, o_upd_cy} = 2'h3;
      end
      OP_CLEAR_SIGNED_OVERRUN: begin
        o_ov = 1'b0;
        o_upd_ov = 1'b1;
      end
      OP_LOAD: begin
        o_a = i_opnd;
        o_wr_a = 1'b1;
      end
      default: ;
    endcase
  end
endmodule // mcrf_arith_unit

// File: logic/mcrf_wait_counter.sv
// Wait-state counter for one memory access at a time.
// Assumes the caller only starts an access while o_busy is low.
`timescale 1ns/100ps
module mcrf_wait_counter
  import mcrf_pkg::*;
(
  input  wire logic       i_clk_sys,  // Core clock
  input  wire logic       i_sys_rst,  // Synchronous reset
  input  wire logic       i_start,    // Access begins
  input  wire logic [2:0] i_waits,    // Wait states for it
  output logic            o_busy,     // Access in progress
  output logic            o_done      // Last cycle of access
);
  typedef struct packed {
    logic       busy;
    logic [2:0] cnt;
  } mcrf_wait_type;

  mcrf_wait_type wc_reg;
  mcrf_wait_type wc_next;

  // Count waits down, finish on zero
  always_comb begin
    wc_next = wc_reg;
    if (wc_reg.busy) begin
      if (wc_reg.cnt == 3'h0) begin
        wc_next.busy = 1'b0;
      end else begin
        wc_next.cnt = wc_reg.cnt - 3'h1;
      end
    end else if (i_start) begin
      wc_next.busy = 1'b1;
      wc_next.cnt = i_waits;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wc_reg <= '0;
    end else begin
      wc_reg <= wc_next;
    end
  end

  assign o_busy = wc_reg.busy;
  assign o_done = wc_reg.busy && (wc_reg.cnt == 3'h0);
endmodule // mcrf_wait_counter

// File: logic/mcrf_core_regs.sv
// Core register set: stack, data pointer, fetch counter, accumulator,
// second operand, four working banks, flags word and access waits.
// Assumes the decode logic drives one-cycle command strobes.
// What this block does
// - Four wait states per access on high-voltage part, five on low.
// - Fetch and data use same waits unless bus timing register differs.
// - Eight-bit stack pointer increments before push, decrements after pop.
// - Stack pointer resets to 07h so first push lands at 08h.
// - Sixteen-bit data pointer built from low and high byte registers.
// - Fetch counter holds next address and resets to 0000h.
// - Accumulator gives operands, takes results; pairs with operand for mul/div.
// - Four banks of eight working registers fill locations 00h-1Fh.
// - Bank select bits map 00,01,10,11 to the four eight-byte blocks.
// - Bank zero is active after reset.
// - Carry set on add carry or subtract borrow; shifts update it too.
// - Half carry follows carry into or borrow from high nibble.
// - User flag changes only by software writes.
// - Overrun set on sign change, product above 255, divide by zero.
// - Overrun cleared otherwise by those ops; clear instruction clears it.
// - Parity bit is odd parity of accumulator, always current.
`timescale 1ns/100ps
module mcrf_core_regs
  import mcrf_pkg::*;
(
  input  wire logic        i_clk_sys,      // Core clock, 100 MHz
  input  wire logic        i_sys_rst,      // Synchronous reset, high
  input  wire logic        i_low_voltage,  // Low-voltage part variant
  input  wire logic [7:0]  i_sfr_addr,     // Direct address
  input  wire logic        i_sfr_wr,       // Direct write strobe
  input  wire logic [7:0]  i_sfr_wdata,    // Direct write data
  output logic      [7:0]  o_sfr_rdata,    // Direct read data
  input  wire logic [3:0]  i_alu_op,       // Arithmetic operation
  input  wire logic [7:0]  i_alu_operand,  // Arithmetic source
  input  wire logic [2:0]  i_wreg_sel,     // Working register index
  input  wire logic        i_wreg_wr,      // Working register write
  input  wire logic [7:0]  i_wreg_wdata,   // Working register data
  output logic      [7:0]  o_wreg_rdata,   // Working register read
  input  wire logic        i_push,         // Stack push strobe
  input  wire logic        i_pop,          // Stack pop strobe
  output logic      [7:0]  o_stack_pointer,       // Stack pointer
  input  wire logic        i_data_pointer_pair_inc,     // Data pointer increment
  output logic      [15:0] o_data_pointer_pair,   // Data pointer
  input  wire logic        i_pc_load,      // Fetch counter load
  input  wire logic [15:0] i_pc_value,     // Fetch counter value
  output logic      [15:0] o_next_fetch_counter,  // Next fetch address
  input  wire logic        i_fetch_req,    // Program fetch request
  input  wire logic        i_data_req,     // Data access request
  output logic             o_mem_busy,     // Access in progress
  output logic             o_mem_ready,    // Access completes
  output logic      [7:0]  o_arith_result_reg,    // Accumulator
  output logic      [7:0]  o_second_operand_reg,  // Second operand
  output logic      [7:0]  o_core_flags_word      // Flags word
);
  typedef struct packed {
    logic [7:0]       sp;
    logic [7:0]       pointer_low_byte;
    logic [7:0]       pointer_high_byte;
    logic [15:0]      pc;
    logic [7:0]       acc;
    logic [7:0]       b;
    logic             cy;
    logic             ac;
    logic             f0;
    logic [1:0]       rs;
    logic             ov;
    logic [7:0]       bustim;
    logic [31:0][7:0] wregs;
    logic [7:0]       rdata;
    logic [7:0]       wrdata;
    logic             fetch_acc;
  } mcrf_state_type;

  mcrf_state_type st_reg;
  mcrf_state_type st_next;

  logic [7:0] au_a;
  logic [7:0] au_b;
  logic       au_cy;
  logic       au_ac;
  logic       au_ov;
  logic       au_wr_a;
  logic       au_wr_b;
  logic       au_upd_cy;
  logic       au_upd_ac;
  logic       au_upd_ov;
  logic       wc_busy;
  logic       wc_done;
  logic       acc_start;
  logic [2:0] def_waits;
  logic [2:0] acc_waits;
  logic [7:0] flags_word;

  // Flags word assembly, parity always from accumulator
  assign flags_word = {st_reg.cy, st_reg.ac, st_reg.f0, st_reg.rs,
                       st_reg.ov, 1'b0, ^st_reg.acc};

  // Arithmetic on the accumulator and second operand
  mcrf_arith_unit u_arith (
    .i_op     (i_alu_op),
    .i_acc    (st_reg.acc),
    .i_b      (st_reg.b),
    .i_opnd   (i_alu_operand),
    .i_cy     (st_reg.cy),
    .o_a      (au_a),
    .o_b      (au_b),
    .o_cy     (au_cy),
    .o_ac     (au_ac),
    .o_ov     (au_ov),
    .o_wr_a   (au_wr_a),
    .o_wr_b   (au_wr_b),
    .o_upd_cy (au_upd_cy),
    .o_upd_ac (au_upd_ac),
    .o_upd_ov (au_upd_ov)
  );

  // Wait-state choice: variant default, or programmed per kind
  assign def_waits = i_low_voltage ? WAIT_LOV : WAIT_HIV;
  assign acc_start = (i_fetch_req || i_data_req) && !wc_busy;
  always_comb begin
    if (!st_reg.bustim[BT_OVR]) begin
      acc_waits = def_waits;
    end else if (i_fetch_req) begin
      acc_waits = st_reg.bustim[BT_FETCH_LSB +: BT_W];
    end else begin
      acc_waits = st_reg.bustim[BT_DATA_LSB +: BT_W];
    end
  end

  mcrf_wait_counter u_wait (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_start   (acc_start),
    .i_waits   (acc_waits),
    .o_busy    (wc_busy),
    .o_done    (wc_done)
  );

  // Next state: software writes first, core strobes override
  always_comb begin
    st_next = st_reg;
    if (i_sfr_wr) begin
      if (i_sfr_addr <= ADDR_WREG_TOP) begin
        st_next.wregs[i_sfr_addr[4:0]] = i_sfr_wdata;
      end else begin
        case (i_sfr_addr)
          ADDR_SP:     st_next.sp = i_sfr_wdata;
          ADDR_DPL:    st_next.pointer_low_byte = i_sfr_wdata;
          ADDR_DPH:    st_next.pointer_high_byte = i_sfr_wdata;
          ADDR_ACC:    st_next.acc = i_sfr_wdata;
          ADDR_B:      st_next.b = i_sfr_wdata;
          ADDR_BUSTIM: st_next.bustim = i_sfr_wdata;
          ADDR_PSW: begin
            st_next.cy = i_sfr_wdata[BIT_CY];
            st_next.ac = i_sfr_wdata[BIT_AC];
            st_next.f0 = i_sfr_wdata[BIT_F0];
            st_next.rs = {i_sfr_wdata[BIT_RS1], i_sfr_wdata[BIT_RS0]};
            st_next.ov = i_sfr_wdata[BIT_OV];
          end
          default: ;
        endcase
      end
    end
    // Read data, unmapped addresses read zero
    if (i_sfr_addr <= ADDR_WREG_TOP) begin
      st_next.rdata = st_reg.wregs[i_sfr_addr[4:0]];
    end else begin
      case (i_sfr_addr)
        ADDR_SP:     st_next.rdata = st_reg.sp;
        ADDR_DPL:    st_next.rdata = st_reg.pointer_low_byte;
        ADDR_DPH:    st_next.rdata = st_reg.pointer_high_byte;
        ADDR_ACC:    st_next.rdata = st_reg.acc;
        ADDR_B:      st_next.rdata = st_reg.b;
        ADDR_BUSTIM: st_next.rdata = st_reg.bustim;
        ADDR_PSW:    st_next.rdata = flags_word;
        default:     st_next.rdata = 8'h00;
      endcase
    end
    // Working registers through the active bank
    if (i_wreg_wr) begin
      st_next.wregs[bank_slot(st_reg.rs, i_wreg_sel)] = i_wreg_wdata;
    end
    st_next.wrdata = st_reg.wregs[bank_slot(st_reg.rs, i_wreg_sel)];
    // Stack pointer movement
    if (i_push && !i_pop) begin
      st_next.sp = st_reg.sp + 8'h01;
    end else if (i_pop && !i_push) begin
      st_next.sp = st_reg.sp - 8'h01;
    end
    // Data pointer as one 16-bit counter
    if (i_data_pointer_pair_inc) begin
      {st_next.pointer_high_byte, st_next.pointer_low_byte} = {st_reg.pointer_high_byte, st_reg.pointer_low_byte} + 16'h0001;
    end
    // Arithmetic results
    if (au_wr_a) begin
      st_next.acc = au_a;
    end
    if (au_wr_b) begin
      st_next.b = au_b;
    end
    if (au_upd_cy) begin
      st_next.cy = au_cy;
    end
    if (au_upd_ac) begin
      st_next.ac = au_ac;
    end
    if (au_upd_ov) begin
      st_next.ov = au_ov;
    end
    // Fetch counter: load, else step after a completed fetch
    if (i_pc_load) begin
      st_next.pc = i_pc_value;
    end else if (wc_done && st_reg.fetch_acc) begin
      st_next.pc = st_reg.pc + 16'h0001;
    end
    if (acc_start) begin
      st_next.fetch_acc = i_fetch_req;
    end
  end

  // State register with reset values
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= '0;
      st_reg.sp <= SP_RST;
      st_reg.pc <= PC_RST;
      st_reg.rs <= BANK_RST;
      st_reg.bustim <= BUSTIM_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign o_sfr_rdata = st_reg.rdata;
  assign o_wreg_rdata = st_reg.wrdata;
  assign o_stack_pointer = st_reg.sp;
  assign o_data_pointer_pair = {st_reg.pointer_high_byte, st_reg.pointer_low_byte};
  assign o_next_fetch_counter = st_reg.pc;
  assign o_mem_busy = wc_busy;
  assign o_mem_ready = wc_done;
  assign o_arith_result_reg = st_reg.acc;
  assign o_second_operand_reg = st_reg.b;
  assign o_core_flags_word = flags_word;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_start_default;
    acc_start && !st_reg.bustim[BT_OVR];
  endsequence
  sequence s_alone_push;
    i_push && !i_pop && !i_sfr_wr;
  endsequence

  chk_reset_values: assert property ($fell(i_sys_rst) |->
    o_stack_pointer == 8'h07 && o_next_fetch_counter == 16'h0000)
    else $error("reset values wrong");
  chk_wait_high: assert property (s_start_default ##0 !i_low_voltage
    |-> ##1 !o_mem_ready [*4] ##1 o_mem_ready)
    else $error("high voltage wait count wrong");
  chk_wait_low: assert property (s_start_default ##0 i_low_voltage
    |-> ##1 !o_mem_ready [*5] ##1 o_mem_ready)
    else $error("low voltage wait count wrong");
  chk_data_same: assert property (s_start_default ##0 i_data_req
    && !i_fetch_req |=> $stable(o_next_fetch_counter) [*2])
    else $error("data access moved fetch counter");
  chk_push_step: assert property (s_alone_push |=>
    o_stack_pointer == $past(o_stack_pointer) + 8'h01)
    else $error("push did not pre-increment");
  chk_bank_write: assert property (i_wreg_wr && !i_sfr_wr &&
    st_reg.rs == 2'h1 && i_wreg_sel == 3'h0 |=>
    st_reg.wregs[8] == $past(i_wreg_wdata))
    else $error("bank one write missed location 08h");
  chk_parity_live: assert property (
    o_core_flags_word[BIT_PAR] == ^o_arith_result_reg &&
    o_core_flags_word[1] == 1'b0)
    else $error("parity bit wrong");
  chk_mul_over: assert property (i_alu_op == OP_PROD &&
    (st_reg.acc * st_reg.b) > 16'd255 |=> o_core_flags_word[BIT_OV]
    && o_second_operand_reg != 8'h00)
    else $error("product overrun not flagged");
  chk_clear_signed_overrun_clear: assert property (i_alu_op == OP_CLEAR_SIGNED_OVERRUN |=>
    !o_core_flags_word[BIT_OV])
    else $error("overrun not cleared");
  chk_user_hold: assert property (!(i_sfr_wr &&
    i_sfr_addr == ADDR_PSW) |=> $stable(o_core_flags_word[BIT_F0]))
    else $error("user flag changed without write");
  chk_data_pointer_pair_carry: assert property (i_data_pointer_pair_inc && !i_sfr_wr &&
    o_data_pointer_pair[7:0] == 8'hff |=> o_data_pointer_pair ==
    $past(o_data_pointer_pair) + 16'h0001)
    else $error("pointer did not carry into high byte");
endmodule // mcrf_core_regs

// File: dv/test_mcu_core_regs_and_flags.sv
// Self-checking bench for the core register set: direct port, stack,
// pointer, banks, arithmetic flags and access waits.
// Assumes a 100 MHz core clock; design assertions sit in the design.
`timescale 1ns/100ps
module test_mcu_core_regs_and_flags
  import mcrf_pkg::*;
;
  logic        i_clk_sys, i_sys_rst, i_low_voltage, i_sfr_wr;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, i_alu_operand, i_wreg_wdata;
  logic [3:0]  i_alu_op;
  logic [2:0]  i_wreg_sel;
  logic        i_wreg_wr, i_push, i_pop, i_data_pointer_pair_inc, i_pc_load;
  logic        i_fetch_req, i_data_req;
  logic [15:0] i_pc_value;
  logic [7:0]  o_sfr_rdata, o_wreg_rdata, o_stack_pointer;
  logic [7:0]  o_arith_result_reg, o_second_operand_reg, o_core_flags_word;
  logic [15:0] o_data_pointer_pair, o_next_fetch_counter;
  logic        o_mem_busy, o_mem_ready;
  int          err_total, n_compared;

  mcrf_core_regs i_mcrf_core_regs (.*);

  // Core clock, 10 ns period
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask

  // Compare one value, report and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Direct write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr  = a;
    i_sfr_wdata = d;
    i_sfr_wr    = 1'b1;
    tick();
    i_sfr_wr    = 1'b0;
  endtask

  // Direct read, data valid after the sampling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_sfr_addr = a;
    tick();
    chk({8'h00, o_sfr_rdata}, {8'h00, e});
  endtask

  // One arithmetic operation
  task automatic alu(input mcrf_op_type op, input logic [7:0] d);
    i_alu_op      = op;
    i_alu_operand = d;
    tick();
    i_alu_op      = OP_NONE;
  endtask

  // One memory access; ready must come waits+1 cycles after taking
  task automatic mem(input logic f, input logic [2:0] w);
    int n;
    i_fetch_req = f;
    i_data_req  = !f;
    tick();
    i_fetch_req = 1'b0;
    i_data_req  = 1'b0;
    n = 1;
    while (o_mem_ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    chk(n[15:0], {13'h0, w} + 16'h1);
    tick();
    chk({15'h0, o_mem_busy}, 16'h0);
  endtask

  // Counts, verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well beyond the roughly ninety cycles of the tests
  initial begin
    #50000;
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    {i_low_voltage, i_sfr_wr, i_wreg_wr, i_push, i_pop} = '0;
    {i_data_pointer_pair_inc, i_pc_load, i_fetch_req, i_data_req} = '0;
    {i_sfr_addr, i_sfr_wdata, i_alu_operand, i_wreg_wdata} = '0;
    i_alu_op = OP_NONE;
    i_wreg_sel = 3'h0;
    i_pc_value = 16'h0000;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    i_sys_rst = 1'b0;
    chk({8'h00, o_stack_pointer}, 16'h0007);
    chk(o_next_fetch_counter, 16'h0000);
    chk({8'h00, o_core_flags_word}, 16'h0000);
    $display("test reset done");
    // Stack: pre-increment push, post-decrement pop
    i_push = 1'b1;
    tick();
    chk({8'h00, o_stack_pointer}, 16'h0008);
    tick();
    i_push = 1'b0;
    i_pop = 1'b1;
    tick();
    i_push = 1'b1;
    tick();
    i_push = 1'b0;
    i_pop = 1'b0;
    chk({8'h00, o_stack_pointer}, 16'h0008);
    wr(ADDR_SP, 8'h2f);
    i_push = 1'b1;
    tick();
    i_push = 1'b0;
    rd(ADDR_SP, 8'h30);
    $display("test stack done");
    // Bank mapping through direct addresses and working port
    for (int b = 0; b < 4; b++)
      wr({3'h0, 2'(b), 3'h5}, 8'ha0 + 8'(b));
    i_wreg_sel = 3'h5;
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_PSW, {3'h0, 2'(b), 3'h0});
      tick();
      chk({8'h00, o_wreg_rdata}, {8'h00, 8'ha0 + 8'(b)});
    end
    wr(ADDR_PSW, 8'h10);
    i_wreg_sel = 3'h6;
    i_wreg_wdata = 8'h5a;
    i_wreg_wr = 1'b1;
    tick();
    i_wreg_wr = 1'b0;
    rd(8'h16, 8'h5a);
    rd(8'h06, 8'h00);
    wr(ADDR_PSW, 8'h08);
    i_wreg_sel = 3'h0;
    i_wreg_wdata = 8'h3c;
    i_wreg_wr = 1'b1;
    tick();
    i_wreg_wr = 1'b0;
    rd(8'h08, 8'h3c);
    $display("test banks done");
    // Arithmetic flags, user flag held set throughout
    wr(ADDR_PSW, 8'h20);
    alu(OP_LOAD, 8'h7f);
    chk({o_arith_result_reg, o_core_flags_word}, 16'h7f21);
    alu(OP_SUM, 8'h01);
    chk({o_arith_result_reg, o_core_flags_word}, 16'h8065);
    alu(OP_SUM, 8'h80);
    chk({o_arith_result_reg, o_core_flags_word}, 16'h00a4);
    alu(OP_SUMC, 8'h00);
    chk({o_arith_result_reg, o_core_flags_word}, 16'h0121);
    alu(OP_DIFB, 8'h02);
    chk({o_arith_result_reg, o_core_flags_word}, 16'hffe0);
    alu(OP_LOAD, 8'h01);
    alu(OP_RRC, 8'h00);
    chk({o_arith_result_reg, 7'h0, o_core_flags_word[7]}, 16'h8001);
    wr(ADDR_B, 8'h20);
    alu(OP_LOAD, 8'h10);
    alu(OP_PROD, 8'h00);
    chk({o_arith_result_reg, o_second_operand_reg}, 16'h0002);
    chk({14'h0, o_core_flags_word[7], o_core_flags_word[2]}, 16'h1);
    alu(OP_CLEAR_SIGNED_OVERRUN, 8'h00);
    chk({15'h0, o_core_flags_word[2]}, 16'h0);
    wr(ADDR_B, 8'h00);
    alu(OP_LOAD, 8'h17);
    alu(OP_QUOT, 8'h00);
    chk({o_arith_result_reg, 7'h0, o_core_flags_word[2]}, 16'h1701);
    wr(ADDR_B, 8'h07);
    alu(OP_QUOT, 8'h00);
    chk({o_arith_result_reg, o_second_operand_reg}, 16'h0302);
    chk({14'h0, o_core_flags_word[5], o_core_flags_word[2]}, 16'h2);
    $display("test arith done");
    // Data pointer bytes and carry between them
    wr(ADDR_DPL, 8'hff);
    wr(ADDR_DPH, 8'h12);
    i_data_pointer_pair_inc = 1'b1;
    tick();
    i_data_pointer_pair_inc = 1'b0;
    chk(o_data_pointer_pair, 16'h1300);
    rd(ADDR_DPH, 8'h13);
    rd(8'h80, 8'h00);
    $display("test pointer done");
    // Wait states per variant and bus timing override
    mem(1'b1, 3'h4);
    i_low_voltage = 1'b1;
    mem(1'b1, 3'h5);
    mem(1'b0, 3'h5);
    chk(o_next_fetch_counter, 16'h0002);
    i_low_voltage = 1'b0;
    wr(ADDR_BUSTIM, 8'ha3);
    mem(1'b1, 3'h2);
    mem(1'b0, 3'h3);
    i_pc_value = 16'h1234;
    i_pc_load = 1'b1;
    tick();
    i_pc_load = 1'b0;
    mem(1'b1, 3'h2);
    chk(o_next_fetch_counter, 16'h1235);
    $display("test memory done");
    close_out();
  end
endmodule // test_mcu_core_regs_and_flags
